// ==== design/cbt_pkg.sv ====
// Constants, carriers and state encodings of the CAN bit timing block
package cbt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PRESC = 8'h08;
  localparam logic [7:0] OFS_SEG = 8'h0C;
  localparam logic [7:0] OFS_TXID0 = 8'h10;
  localparam logic [7:0] OFS_TXID1 = 8'h14;
  localparam logic [7:0] OFS_TXID2 = 8'h18;
  localparam logic [7:0] OFS_TXID3 = 8'h1C;
  localparam logic [7:0] OFS_RXID0 = 8'h20;
  localparam logic [7:0] OFS_RXID1 = 8'h24;
  localparam logic [7:0] OFS_RXID2 = 8'h28;
  localparam logic [7:0] OFS_RXID3 = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_INIT_REQ = 0;
  localparam int CTRL_START = 1;
  localparam int STAT_INIT_ACK = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_ARB_LOST = 2;
  localparam int STAT_RX_DONE = 3;
  localparam int SEG_TRIPLE_SAMPLE_SELECT = 7;
  localparam int ID1_SRR = 4;
  localparam int ID1_IDE = 3;

  // ----------------------------------------------------------------
  // Reset values and frame lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] SEG_RST = 8'h00;
  localparam logic [5:0] PRESC_RST = 6'h00;
  localparam logic [5:0] FRAME_EXT_LEN = 6'h20;
  localparam logic [5:0] FRAME_STD_LEN = 6'h0D;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } cbt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cbt_apb_rsp_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } cbt_mode_e;

  typedef struct packed {
    cbt_apb_rsp_s rsp;
    logic rx_m;
    logic rx_s;
    logic init_mode_request;
    logic init_mode_acknowledge;
    logic arb_lost;
    logic rx_done;
    logic [5:0] quantum_prescaler;
    logic [7:0] bus_timing_segments;
    logic [7:0] tx_id_high;
    logic [7:0] tx_id_mid_flags;
    logic [7:0] tx_id_low_mid;
    logic [6:0] tx_id_low;
    logic [7:0] rx_id_high;
    logic [7:0] rx_id_mid_flags;
    logic [7:0] rx_id_low_mid;
    logic [6:0] rx_id_low;
    cbt_mode_e mode;
    logic [5:0] pcnt;
    logic [4:0] quanta;
    logic [5:0] bidx;
    logic [5:0] flen;
    logic [31:0] frame;
    logic [31:0] rxsh;
    logic [1:0] hist;
    logic sending;
    logic tx;
    logic rx_bit;
    logic rx_bit_stb;
  } cbt_state_s;

endpackage : cbt_pkg

// ==== design/cbt_core.sv ====
// CAN bit timing, extended identifier buffers and arbitration engine
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
module cbt_core (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire cbt_pkg::cbt_apb_req_s apb_req,
  output cbt_pkg::cbt_apb_rsp_s apb_rsp,
  input wire logic can_rx,
  output logic can_tx,
  output logic rx_bit,
  output logic rx_bit_stb
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cbt_pkg::cbt_state_s s_q;
  cbt_pkg::cbt_state_s s_d;

  assign apb_rsp = s_q.rsp;
  assign can_tx = s_q.tx;
  assign rx_bit = s_q.rx_bit;
  assign rx_bit_stb = s_q.rx_bit_stb;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Two of three wins, so one disturbed quantum cannot flip a bit
  function automatic logic vote3(
    input logic a,
    input logic b,
    input logic c
  );
    return (a & b) | (a & c) | (b & c);
  endfunction : vote3

  // Quantum index that closes with the nominal sample point
  function automatic logic [4:0] sample_index(input logic [3:0] seg1);
    return 5'(seg1) + 5'h01;
  endfunction : sample_index

  // Quantum index that closes the bit: sync, segment one, segment two
  function automatic logic [4:0] last_index(
    input logic [3:0] seg1,
    input logic [2:0] seg2
  );
    return 5'(seg1) + 5'(seg2) + 5'h02;
  endfunction : last_index

  // Sent bits, start bit at the top; a standard frame stops after its flag
  function automatic logic [31:0] tx_frame(
    input logic [7:0] hi,
    input logic [7:0] mid,
    input logic [7:0] lm,
    input logic [6:0] lo
  );
    logic [31:0] f;
    if (mid[cbt_pkg::ID1_IDE]) begin
      // Substitute remote bit goes out exactly as software wrote it
      f = {1'h0, hi, mid, lm, lo};
    end else begin
      f = {1'h0, hi, mid[7:5], 1'h0, 19'h0};
    end
    return f;
  endfunction : tx_frame

  // Received bits in register order; short frames are left aligned
  function automatic logic [31:0] rx_frame(
    input logic [31:0] sh,
    input logic ext
  );
    logic [31:0] f;
    if (ext) begin
      f = sh;
    end else begin
      f = {sh[12:0], 19'h0};
    end
    return f;
  endfunction : rx_frame

  // Write one to clear; a hardware set later in the cycle overrides it
  function automatic logic w1c(input logic flag, input logic clr);
    return flag && !clr;
  endfunction : w1c

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rdata;
    logic hit;
    logic wr;
    logic cfg_ok;
    logic tick;
    logic [3:0] t1;
    logic [2:0] t2;
    logic [4:0] spt;
    logic [4:0] last;
    logic smp;
    logic [5:0] nb;
    logic [31:0] rf;
    logic [31:0] ws;
    rdata = 32'h0;
    hit = 1'b1;
    wr = 1'b0;
    cfg_ok = 1'b0;
    tick = 1'b0;
    t1 = 4'h0;
    t2 = 3'h0;
    spt = 5'h0;
    last = 5'h0;
    smp = 1'b1;
    nb = 6'h0;
    rf = 32'h0;
    ws = apb_req.pwdata;
    s_d = s_q;
    s_d.rx_bit_stb = 1'b0;
    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    // Pin passes two flops before anything looks at it
    s_d.rx_m = can_rx;
    s_d.rx_s = s_q.rx_m;

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    unique case (apb_req.paddr)
      cbt_pkg::OFS_CTRL: begin
        rdata[cbt_pkg::CTRL_INIT_REQ] = s_q.init_mode_request;
      end
      cbt_pkg::OFS_STAT: begin
        rdata[cbt_pkg::STAT_INIT_ACK] = s_q.init_mode_acknowledge;
        rdata[cbt_pkg::STAT_BUSY] = (s_q.mode == cbt_pkg::ST_FRAME);
        rdata[cbt_pkg::STAT_ARB_LOST] = s_q.arb_lost;
        rdata[cbt_pkg::STAT_RX_DONE] = s_q.rx_done;
      end
      cbt_pkg::OFS_PRESC: begin
        rdata[5:0] = s_q.quantum_prescaler;
      end
      cbt_pkg::OFS_SEG: begin
        rdata[7:0] = s_q.bus_timing_segments;
      end
      cbt_pkg::OFS_TXID0: begin
        rdata[7:0] = s_q.tx_id_high;
      end
      cbt_pkg::OFS_TXID1: begin
        rdata[7:0] = s_q.tx_id_mid_flags;
      end
      cbt_pkg::OFS_TXID2: begin
        rdata[7:0] = s_q.tx_id_low_mid;
      end
      cbt_pkg::OFS_TXID3: begin
        rdata[6:0] = s_q.tx_id_low;
      end
      cbt_pkg::OFS_RXID0: begin
        rdata[7:0] = s_q.rx_id_high;
      end
      cbt_pkg::OFS_RXID1: begin
        rdata[7:0] = s_q.rx_id_mid_flags;
      end
      cbt_pkg::OFS_RXID2: begin
        rdata[7:0] = s_q.rx_id_low_mid;
      end
      cbt_pkg::OFS_RXID3: begin
        rdata[6:0] = s_q.rx_id_low;
      end
      default: hit = 1'b0;
    endcase

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // One wait state, so every answer comes from a flop
    if (apb_req.psel && apb_req.penable && !s_q.rsp.pready) begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.prdata = rdata;
      s_d.rsp.pslverr = !hit;
    end else begin
      s_d.rsp.pready = 1'b0;
      s_d.rsp.pslverr = 1'b0;
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    wr = apb_req.psel && apb_req.penable && s_q.rsp.pready
      && apb_req.pwrite;
    cfg_ok = s_q.init_mode_request && s_q.init_mode_acknowledge;
    if (wr) begin
      unique case (apb_req.paddr)
        cbt_pkg::OFS_CTRL: begin
          // Request may only drop once it has been acknowledged
          if (ws[cbt_pkg::CTRL_INIT_REQ] || s_q.init_mode_acknowledge) begin
            s_d.init_mode_request = ws[cbt_pkg::CTRL_INIT_REQ];
          end
          if (ws[cbt_pkg::CTRL_START] && !s_q.init_mode_request
              && !ws[cbt_pkg::CTRL_INIT_REQ]
              && s_q.mode == cbt_pkg::ST_IDLE) begin
            s_d.mode = cbt_pkg::ST_FRAME;
            s_d.pcnt = 6'h0;
            s_d.quanta = 5'h0;
            s_d.bidx = 6'h0;
            s_d.hist = 2'b11;
            s_d.sending = 1'b1;
            s_d.frame = tx_frame(s_q.tx_id_high, s_q.tx_id_mid_flags,
              s_q.tx_id_low_mid, s_q.tx_id_low);
            s_d.flen = s_q.tx_id_mid_flags[cbt_pkg::ID1_IDE]
              ? cbt_pkg::FRAME_EXT_LEN : cbt_pkg::FRAME_STD_LEN;
            s_d.tx = 1'b0;
          end
        end
        cbt_pkg::OFS_STAT: begin
          s_d.arb_lost = w1c(s_q.arb_lost, ws[cbt_pkg::STAT_ARB_LOST]);
          s_d.rx_done = w1c(s_q.rx_done, ws[cbt_pkg::STAT_RX_DONE]);
        end
        cbt_pkg::OFS_PRESC: begin
          if (cfg_ok) begin
            s_d.quantum_prescaler = ws[5:0];
          end
        end
        cbt_pkg::OFS_SEG: begin
          if (cfg_ok) begin
            s_d.bus_timing_segments = ws[7:0];
          end
        end
        cbt_pkg::OFS_TXID0: begin
          s_d.tx_id_high = ws[7:0];
        end
        cbt_pkg::OFS_TXID1: begin
          s_d.tx_id_mid_flags = ws[7:0];
        end
        cbt_pkg::OFS_TXID2: begin
          s_d.tx_id_low_mid = ws[7:0];
        end
        cbt_pkg::OFS_TXID3: begin
          s_d.tx_id_low = ws[6:0];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Mode handshake
    // ----------------------------------------------------------------
    // Acknowledge trails the request by one cycle
    s_d.init_mode_acknowledge = s_q.init_mode_request;

    // ----------------------------------------------------------------
    // Bit timing engine
    // ----------------------------------------------------------------
    t1 = s_q.bus_timing_segments[3:0];
    t2 = s_q.bus_timing_segments[6:4];
    spt = sample_index(t1);
    last = last_index(t1, t2);
    tick = (s_q.pcnt == s_q.quantum_prescaler);
    nb = s_q.bidx + 6'h01;

    if (s_q.mode == cbt_pkg::ST_FRAME) begin
      s_d.pcnt = tick ? 6'h0 : s_q.pcnt + 6'h01;
      if (tick) begin
        // Keep the two previous quanta for the vote
        s_d.hist = {s_q.hist[0], s_q.rx_s};
        s_d.quanta = s_q.quanta + 5'h01;
        if (s_q.quanta == spt) begin
          if (s_q.bus_timing_segments[cbt_pkg::SEG_TRIPLE_SAMPLE_SELECT]) begin
            smp = vote3(s_q.hist[1], s_q.hist[0], s_q.rx_s);
          end else begin
            smp = s_q.rx_s;
          end
          s_d.rx_bit = smp;
          s_d.rx_bit_stb = 1'b1;
          s_d.rxsh = {s_q.rxsh[30:0], smp};
          // Recessive sent, dominant seen: a smaller identifier won
          if (s_q.sending && s_q.tx && !smp && s_q.bidx != 6'h0) begin
            s_d.sending = 1'b0;
            s_d.tx = 1'b1;
            s_d.arb_lost = 1'b1;
          end
        end
        if (s_q.quanta == last) begin
          s_d.quanta = 5'h0;
          s_d.bidx = nb;
          if (nb == s_q.flen) begin
            s_d.mode = cbt_pkg::ST_IDLE;
            s_d.tx = 1'b1;
            s_d.sending = 1'b0;
            rf = rx_frame(s_q.rxsh, s_q.flen == cbt_pkg::FRAME_EXT_LEN);
            s_d.rx_id_high = rf[30:23];
            s_d.rx_id_mid_flags = rf[22:15];
            s_d.rx_id_low_mid = rf[14:7];
            s_d.rx_id_low = rf[6:0];
            s_d.rx_done = 1'b1;
          end else if (s_d.sending) begin
            s_d.tx = s_q.frame[5'(5'h1F - nb[4:0])];
          end
        end
      end
    end

    // ----------------------------------------------------------------
    // Abort
    // ----------------------------------------------------------------
    // Init mode aborts a frame and releases the line at once
    if (s_q.init_mode_request) begin
      s_d.mode = cbt_pkg::ST_IDLE;
      s_d.tx = 1'b1;
      s_d.sending = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.mode <= cbt_pkg::ST_IDLE;
      s_q.bus_timing_segments <= cbt_pkg::SEG_RST;
      s_q.quantum_prescaler <= cbt_pkg::PRESC_RST;
      s_q.tx <= 1'b1;
      s_q.rx_m <= 1'b1;
      s_q.rx_s <= 1'b1;
      s_q.hist <= 2'b11;
      s_q.rx_bit <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule : cbt_core

// ==== verif/cbt_core_asserts.sv ====
// Port checker of the CAN bit timing block
`timescale 1ns/10ps
module cbt_core_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire cbt_pkg::cbt_apb_req_s apb_req,
  input wire cbt_pkg::cbt_apb_rsp_s apb_rsp,
  input wire logic can_rx,
  input wire logic can_tx,
  input wire logic rx_bit,
  input wire logic rx_bit_stb
);
  // ----------------------------------------
  // Relations at the ports
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  rdy_pulse_a: assert property (ce && apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held beyond one cycle");
  rdy_wait_a: assert property (ce && apb_req.psel && !apb_req.penable
    |=> !apb_rsp.pready ##1 apb_rsp.pready) else $error("wait state wrong");
  rdy_cause_a: assert property (apb_rsp.pready |-> $past(apb_req.penable))
    else $error("pready without access phase");
  err_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready &&
    apb_rsp.prdata == 32'h0) else $error("error answer not clean");
  word_pad_a: assert property (apb_rsp.pready |->
    apb_rsp.prdata[31:8] == 24'h0) else $error("upper read bits not zero");
  stb_gap_a: assert property (rx_bit_stb |=> !rx_bit_stb [*2])
    else $error("bit strobes too close");
  rxbit_hold_a: assert property (!rx_bit_stb |-> $stable(rx_bit))
    else $error("received bit changed without strobe");
  sof_hold_a: assert property ($fell(can_tx) && !apb_req.psel
    |-> !can_tx [*3]) else $error("dominant bit cut short");
  reset_out_a: assert property (!$past(rstn) |-> can_tx && rx_bit &&
    !apb_rsp.pready && !rx_bit_stb) else $error("outputs not at reset");
endmodule : cbt_core_asserts

bind cbt_core cbt_core_asserts cbt_core_asserts_inst (.clock(clock),
  .rstn(rstn), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .can_rx(can_rx), .can_tx(can_tx), .rx_bit(rx_bit),
  .rx_bit_stb(rx_bit_stb));

// ==== verif/cbt_bus_node.sv ====
// Other node on the shared CAN bus, with optional line delay
`timescale 1ns/10ps
module cbt_bus_node (
  input wire logic clock,
  input wire logic can_tx,
  input wire logic dominant,
  input wire logic slow,
  output logic can_rx
);
  logic line_q;
  always_ff @(posedge clock) begin
    line_q <= can_tx & ~dominant;
  end
  // Wired-AND bus: any dominant zero wins; slow adds one clock of delay
  assign can_rx = slow ? line_q : (can_tx & ~dominant);
endmodule : cbt_bus_node

// ==== verif/tb_cbt_core.sv ====
// Self-checking bench of the CAN bit timing block
`timescale 1ns/10ps
module tb_cbt_core;
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic dominant = 1'h0;
  logic slow = 1'h0;
  logic ce = 1'h1;
  logic can_tx, can_rx, rx_bit, rx_bit_stb, rerr;
  cbt_pkg::cbt_apb_req_s req = '0;
  cbt_pkg::cbt_apb_rsp_s rsp;
  logic [31:0] rdat;
  logic [31:0] bits = 32'h0;
  logic [15:0] seed = 16'h0046;
  int n_errors = 0;
  int checks = 0;
  int cnt = 0;
  int gap = 0;
  always #12.5 clock = ~clock;
  cbt_core cbt_core_inst (.clock(clock), .rstn(rstn), .ce(ce),
    .apb_req(req), .apb_rsp(rsp), .can_rx(can_rx), .can_tx(can_tx),
    .rx_bit(rx_bit), .rx_bit_stb(rx_bit_stb));
  cbt_bus_node cbt_bus_node_inst (.clock(clock), .can_tx(can_tx),
    .dominant(dominant), .slow(slow), .can_rx(can_rx));
  // ----------------------------------------
  // Bit capture and bit length
  // ----------------------------------------
  always @(negedge clock) begin
    cnt <= (rx_bit_stb === 1'h1) ? 1 : cnt + 1;
    if (rx_bit_stb === 1'h1) begin
      gap <= cnt;
      bits <= {bits[30:0], rx_bit};
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] frame_bits(input logic [28:0] id,
      input logic ide);
    if (ide) return {1'h0, id[28:18], 2'h3, id[17:0]};
    return {19'h0, 1'h0, id[28:18], 1'h0};
  endfunction : frame_bits
  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    @(posedge clock);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'h1;
    @(posedge clock);
    req.penable <= 1'h1;
    // Ready and data are taken as they stand at the sampling edge
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'h1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m);
    apb(a, 1'h0, 32'h0);
    chk(nm, e & m, rdat & m);
  endtask : rdc
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // One frame: configure, send, compare
  // ----------------------------------------
  task automatic run(input int k, input logic dom);
    logic [28:0] id;
    logic [7:0] seg;
    logic [7:0] t [4];
    logic [5:0] p;
    logic ide;
    logic [31:0] got;
    seed = lfsr(seed);
    id = {1'h1, seed, seed[11:0]};
    ide = k[0] | dom;
    p = 6'(k * 2);
    // Triple sampling only at slow rates, phase one of two quanta or more
    seg = {k[1], seed[6:4], 4'(seed[1:0]) + 4'h2};
    t[0] = id[28:21];
    t[1] = {id[20:18], 1'h1, ide, id[17:15]};
    t[2] = id[14:7];
    t[3] = {1'h0, id[6:0]};
    apb(cbt_pkg::OFS_CTRL, 1'h1, 32'h1);
    apb(cbt_pkg::OFS_PRESC, 1'h1, 32'(p));
    apb(cbt_pkg::OFS_SEG, 1'h1, 32'(seg));
    rdc("seg", cbt_pkg::OFS_SEG, 32'(seg), 32'hFF);
    apb(cbt_pkg::OFS_CTRL, 1'h1, 32'h0);
    for (int i = 0; i < 4; i++)
      apb(cbt_pkg::OFS_TXID0 + 8'(4 * i), 1'h1, 32'(t[i]));
    dominant <= dom;
    slow <= k[0] ^ k[1];
    apb(cbt_pkg::OFS_CTRL, 1'h1, 32'h2);
    // Poll at least once: the start write itself reads back no busy bit
    do begin
      apb(cbt_pkg::OFS_STAT, 1'h0, 32'h0);
    end while (rdat[cbt_pkg::STAT_BUSY] !== 1'h0);
    dominant <= 1'h0;
    if (dom) begin
      rdc("arb", cbt_pkg::OFS_STAT, 32'h4, 32'h4);
      rdc("rxid1", cbt_pkg::OFS_RXID1, 32'h0, 32'hE8);
    end else begin
      // A standard frame fills only the low thirteen bits
      got = ide ? bits : {19'h0, bits[12:0]};
      chk("bits", frame_bits(id, ide), got);
      chk("gap", 32'((p + 1) * (seg[3:0] + seg[6:4] + 3)), 32'(gap));
      rdc("done", cbt_pkg::OFS_STAT, 32'h8, 32'h8);
      for (int i = 0; i < 4; i++)
        rdc("rxid", cbt_pkg::OFS_RXID0 + 8'(4 * i), 32'(t[i]),
          32'(i == 0 || ide ? 8'hFF : (i == 1 ? 8'hE8 : 8'h0)));
    end
    apb(cbt_pkg::OFS_STAT, 1'h1, 32'hC);
    rdc("clr", cbt_pkg::OFS_STAT, 32'h0, 32'hC);
  endtask : run
  initial begin
    #(25 * 90000);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'h1;
    rdc("seg0", cbt_pkg::OFS_SEG, 32'h0, 32'hFFFFFFFF);
    apb(cbt_pkg::OFS_SEG, 1'h1, 32'hFF);
    rdc("seglock", cbt_pkg::OFS_SEG, 32'h0, 32'hFFFFFFFF);
    apb(8'h30, 1'h0, 32'h0);
    chk("slverr", 32'h1, 32'(rerr));
    // Clock enable low must hold the answer back until it returns
    ce <= 1'h0;
    fork
      apb(cbt_pkg::OFS_CTRL, 1'h1, 32'h1);
      begin
        repeat (8) @(posedge clock);
        chk("frozen", 32'h0, 32'(rsp.pready));
        ce <= 1'h1;
      end
    join
    rdc("initreq", cbt_pkg::OFS_CTRL, 32'h1, 32'h1);
    for (int k = 0; k < 5; k++)
      run(k, k == 4);
    summarize();
  end
endmodule : tb_cbt_core
